// [logic/bacr_pkg.sv]
package bacr_pkg;

  // bus slave shape
  localparam int          APB_ADDR_W   = 12;
  localparam int          APB_DATA_W   = 32;
  localparam logic [11:0] CFG_OFFSET   = 12'h000;   // configuration word address

  // configuration word layout
  localparam int          CFG_W        = 16;
  localparam logic [15:0] CFG_RESET    = 16'h0000;
  localparam logic [15:0] CFG_WR_MASK  = 16'hF7FF;  // endian bit is read-only
  localparam int          BIT_ADDR_PULLUP_BIT     = 15;
  localparam int          BIT_DATA_PULLUP_BIT     = 14;
  localparam int          BIT_STANDBY_STROBE_FLOAT_CTL   = 13;
  localparam int          BIT_ROW_COL_STROBE_FLOAT_CTL   = 12;
  localparam int          BIT_ENDIAN   = 11;
  localparam int          A0_BST_HI    = 10;
  localparam int          A0_BST_LO    = 9;
  localparam int          A5_BST_HI    = 8;
  localparam int          A5_BST_LO    = 7;
  localparam int          A6_BST_HI    = 6;
  localparam int          A6_BST_LO    = 5;
  localparam int          MEMTYPE_HI   = 4;
  localparam int          MEMTYPE_LO   = 2;
  localparam int          BIT_A5_CARD  = 1;
  localparam int          BIT_A6_CARD  = 0;

  // area 2/3 memory type codes
  localparam logic [2:0]  MT_ORDINARY  = 3'h0;
  localparam logic [2:0]  MT_A3_SDRAM  = 3'h2;
  localparam logic [2:0]  MT_BOTH_SDR  = 3'h3;

  // burst lengths in accesses
  localparam int          BLEN_W       = 5;
  localparam logic [4:0]  BLEN_NONE    = 5'h00;
  localparam logic [4:0]  BLEN_4       = 5'h04;
  localparam logic [4:0]  BLEN_8       = 5'h08;
  localparam logic [4:0]  BLEN_16      = 5'h10;

  // address pull-up window after bus grant acknowledge
  localparam int          PULL_CYCLES  = 4;
  localparam int          PULL_CNT_W   = 3;

  // burst code to number of accesses
  function automatic logic [4:0] burst_len(input logic [1:0] code);
    case (code)
      2'h1:    burst_len = BLEN_4;
      2'h2:    burst_len = BLEN_8;
      2'h3:    burst_len = BLEN_16;
      default: burst_len = BLEN_NONE;
    endcase
  endfunction

endpackage

// [logic/bacr_pull_if.sv]
`timescale 1ns/1ps
`default_nettype none
interface bacr_pull_if;
  logic addr_pullup_bit_en;     // address pull-up feature enabled
  logic addr_pull;   // pull-up window active
  modport ctl (output addr_pullup_bit_en, input addr_pull);
  modport tmr (input addr_pullup_bit_en, output addr_pull);
endinterface : bacr_pull_if
`default_nettype wire

// [logic/bacr_pull_timer.sv]
`timescale 1ns/1ps
`default_nettype none
module bacr_pull_timer
  import bacr_pkg::*;
(
  input  wire logic clk,
  input  wire logic rstn,
  input  wire logic ce,
  input  wire logic grant_ack_n_pin,
  bacr_pull_if.tmr  pull
);

  logic                  ack_s1_q;
  logic                  ack_s2_q;
  logic                  ack_prev_q;
  logic [PULL_CNT_W-1:0] cnt_q;
  logic [PULL_CNT_W-1:0] cnt_d;
  wire                   ack_fall;

  // acknowledge asserts on its falling edge, seen after the second stage
  assign ack_fall = ack_prev_q & ~ack_s2_q;

  // load the window on assertion, then count it down
  assign cnt_d = (ack_fall && pull.addr_pullup_bit_en) ? PULL_CNT_W'(PULL_CYCLES) :
                 (cnt_q != '0) ? cnt_q - 1'b1 : cnt_q;

  assign pull.addr_pull = (cnt_q != '0);

  // pin synchroniser and window counter
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ack_s1_q   <= 1'b1;
      ack_s2_q   <= 1'b1;
      ack_prev_q <= 1'b1;
      cnt_q      <= '0;
    end else if (ce) begin
      ack_s1_q   <= grant_ack_n_pin;
      ack_s2_q   <= ack_s1_q;
      ack_prev_q <= ack_s2_q;
      cnt_q      <= cnt_d;
    end
  end

  a_pull_window: assert property (@(posedge clk) disable iff (!rstn || !ce)
    ack_fall && pull.addr_pullup_bit_en |=> pull.addr_pull [*4] ##1 !pull.addr_pull)
    else $error("address pull-up window is not four cycles");

  a_pull_off: assert property (@(posedge clk) disable iff (!rstn)
    !pull.addr_pull && !(ack_fall && pull.addr_pullup_bit_en) |=> !pull.addr_pull)
    else $error("address pull-up without acknowledge");

endmodule : bacr_pull_timer
`default_nettype wire

// [logic/bacr_top.sv]
// The placing of the registers and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - 16-bit register, read/write except read-only endian bit 11, other bits zero at power-on
// - manual reset and standby keep contents
// - address pull-up four cycles after grant
// - data pull-up while data bus idle
// - standby strobes float or drive high
// - row/column strobes float or stay driven
// - endian pin latched at power-on reset
// - area 0 burst length from two bits
// - area 5 burst length from two bits
// - area 6 burst length from two bits
// - area 2/3 memory type decode, reserved codes flagged
// - area 5 card space when bit set
// - area 6 card space when bit set
module bacr_top
  import bacr_pkg::*;
(
  input  wire logic                  CLK_SYS,
  input  wire logic                  RSTN,
  input  wire logic                  CE,
  input  wire logic                  PSEL,
  input  wire logic                  PENABLE,
  input  wire logic                  PWRITE,
  input  wire logic [APB_ADDR_W-1:0] PADDR,
  input  wire logic [APB_DATA_W-1:0] PWDATA,
  input  wire logic [3:0]            PSTRB,
  output logic      [APB_DATA_W-1:0] PRDATA,
  output logic                       PREADY,
  output logic                       PSLVERR,
  input  wire logic                  BYTE_ORDER_MODE_PIN,
  input  wire logic                  GRANT_ACK_N_PIN,
  input  wire logic                  MANUAL_RESET,
  input  wire logic                  STANDBY,
  input  wire logic                  BUS_RELEASED,
  input  wire logic                  DATA_BUS_IDLE,
  output logic                       ADDR_PULLUP,
  output logic                       DATA_PULLUP,
  output logic                       MEM_STROBE_HIZ,
  output logic                       MEM_STROBE_HIGH,
  output logic                       RAS_CAS_HIZ,
  output logic                       LITTLE_ENDIAN,
  output logic      [BLEN_W-1:0]     AREA0_BURST_LEN,
  output logic      [BLEN_W-1:0]     AREA5_BURST_LEN,
  output logic      [BLEN_W-1:0]     AREA6_BURST_LEN,
  output logic                       AREA2_SDRAM,
  output logic                       AREA3_SDRAM,
  output logic                       AREA5_CARD,
  output logic                       AREA6_CARD,
  output logic                       MEMTYPE_RESERVED
);

  // register and answer state
  logic [CFG_W-1:0]      cfg_q;
  logic [CFG_W-1:0]      cfg_d;
  logic                  endian_q;
  logic                  captured_q;
  logic [1:0]            mode_fill_q;
  logic                  mode_s1_q;
  logic                  mode_s2_q;
  logic                  pready_q;
  logic                  pready_d;
  logic                  pslverr_q;
  logic [APB_DATA_W-1:0] prdata_q;
  logic [APB_DATA_W-1:0] prdata_d;

  // registered pin and area controls
  logic                  addr_pull_q;
  logic                  data_pull_q;
  logic                  strobe_hiz_q;
  logic                  strobe_high_q;
  logic                  ras_cas_hiz_q;
  logic [BLEN_W-1:0]     a0_len_q;
  logic [BLEN_W-1:0]     a5_len_q;
  logic [BLEN_W-1:0]     a6_len_q;
  logic                  a2_sdram_q;
  logic                  a3_sdram_q;
  logic                  a5_card_q;
  logic                  a6_card_q;
  logic                  mt_rsvd_q;

  bacr_pull_if pull ();

  // bus phase decode
  wire                   setup_ph    = PSEL & ~PENABLE;
  wire                   access_done = PSEL & PENABLE & pready_q;
  wire                   addr_hit    = (PADDR == CFG_OFFSET);
  wire                   wr_fire     = access_done & PWRITE & addr_hit;
  wire [CFG_W-1:0]       lane_mask   = {{8{PSTRB[1]}}, {8{PSTRB[0]}}};
  wire [CFG_W-1:0]       wr_mask     = lane_mask & CFG_WR_MASK;
  wire [CFG_W-1:0]       read_value  = cfg_q | (CFG_W'(endian_q) << BIT_ENDIAN);

  // field decode
  wire                   addr_pullup_bit        = cfg_q[BIT_ADDR_PULLUP_BIT];
  wire                   data_pullup_bit        = cfg_q[BIT_DATA_PULLUP_BIT];
  wire                   standby_strobe_float_ctl      = cfg_q[BIT_STANDBY_STROBE_FLOAT_CTL];
  wire                   row_col_strobe_float_ctl      = cfg_q[BIT_ROW_COL_STROBE_FLOAT_CTL];
  wire [1:0]             a0_code     = cfg_q[A0_BST_HI:A0_BST_LO];
  wire [1:0]             a5_code     = cfg_q[A5_BST_HI:A5_BST_LO];
  wire [1:0]             a6_code     = cfg_q[A6_BST_HI:A6_BST_LO];
  wire [2:0]             mt_code     = cfg_q[MEMTYPE_HI:MEMTYPE_LO];
  wire                   mt_a3_sd    = (mt_code == MT_A3_SDRAM) | (mt_code == MT_BOTH_SDR);
  wire                   mt_a2_sd    = (mt_code == MT_BOTH_SDR);
  wire                   mt_bad      = ~mt_a3_sd & (mt_code != MT_ORDINARY);

  // strap is taken only once both synchroniser stages hold the pin
  wire                   capture_now = mode_fill_q[1] & ~captured_q;

  // byte-lane merge; only a completed write changes the word
  assign cfg_d    = wr_fire ? ((cfg_q & ~wr_mask) | (PWDATA[CFG_W-1:0] & wr_mask))
                            : cfg_q;

  // no wait state: ready rises in the first access cycle
  assign pready_d = setup_ph ? 1'b1 : (access_done ? 1'b0 : pready_q);
  assign prdata_d = (setup_ph && addr_hit) ? {{(APB_DATA_W-CFG_W){1'b0}}, read_value}
                                           : prdata_q;

  assign pull.addr_pullup_bit_en = addr_pullup_bit;

  bacr_pull_timer u_pull_timer (
    .clk             (CLK_SYS),
    .rstn            (RSTN),
    .ce              (CE),
    .grant_ack_n_pin (GRANT_ACK_N_PIN),
    .pull            (pull)
  );

  // configuration word, cleared by power-on reset only
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      cfg_q <= CFG_RESET;
    end else if (CE) begin
      cfg_q <= cfg_d;
    end
  end

  // endian strap sampled once, after the synchroniser has filled
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      mode_s1_q  <= 1'b0;
      mode_s2_q  <= 1'b0;
      mode_fill_q <= 2'b00;
      endian_q   <= 1'b0;
      captured_q <= 1'b0;
    end else if (CE) begin
      mode_s1_q <= BYTE_ORDER_MODE_PIN;
      mode_s2_q <= mode_s1_q;
      mode_fill_q <= {mode_fill_q[0], 1'b1};
      if (capture_now) begin
        endian_q   <= mode_s2_q;
        captured_q <= 1'b1;
      end
    end
  end

  // bus answer; a manual reset drops any pending answer, not the word
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else if (CE) begin
      pready_q  <= pready_d & ~MANUAL_RESET;
      prdata_q  <= prdata_d;
      if (setup_ph) begin
        pslverr_q <= ~addr_hit;
      end
    end
  end

  // pin controls: pull-ups, and strobes during standby and bus release
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      addr_pull_q   <= 1'b0;
      data_pull_q   <= 1'b0;
      strobe_hiz_q  <= 1'b0;
      strobe_high_q <= 1'b0;
      ras_cas_hiz_q <= 1'b0;
    end else if (CE) begin
      addr_pull_q   <= pull.addr_pull;
      data_pull_q   <= data_pullup_bit & DATA_BUS_IDLE;
      strobe_hiz_q  <= STANDBY & ~standby_strobe_float_ctl;
      strobe_high_q <= STANDBY & standby_strobe_float_ctl;
      ras_cas_hiz_q <= (STANDBY | BUS_RELEASED) & ~row_col_strobe_float_ctl;
    end
  end

  // area access modes
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      a0_len_q   <= BLEN_NONE;
      a5_len_q   <= BLEN_NONE;
      a6_len_q   <= BLEN_NONE;
      a2_sdram_q <= 1'b0;
      a3_sdram_q <= 1'b0;
      a5_card_q  <= 1'b0;
      a6_card_q  <= 1'b0;
      mt_rsvd_q  <= 1'b0;
    end else if (CE) begin
      a0_len_q   <= burst_len(a0_code);
      a5_len_q   <= burst_len(a5_code);
      a6_len_q   <= burst_len(a6_code);
      a2_sdram_q <= mt_a2_sd;
      a3_sdram_q <= mt_a3_sd;
      a5_card_q  <= cfg_q[BIT_A5_CARD];
      a6_card_q  <= cfg_q[BIT_A6_CARD];
      mt_rsvd_q  <= mt_bad;
    end
  end

  // outputs straight from flip-flops
  assign PRDATA           = prdata_q;
  assign PREADY           = pready_q;
  assign PSLVERR          = pslverr_q;
  assign ADDR_PULLUP      = addr_pull_q;
  assign DATA_PULLUP      = data_pull_q;
  assign MEM_STROBE_HIZ   = strobe_hiz_q;
  assign MEM_STROBE_HIGH  = strobe_high_q;
  assign RAS_CAS_HIZ      = ras_cas_hiz_q;
  assign LITTLE_ENDIAN    = endian_q;
  assign AREA0_BURST_LEN  = a0_len_q;
  assign AREA5_BURST_LEN  = a5_len_q;
  assign AREA6_BURST_LEN  = a6_len_q;
  assign AREA2_SDRAM      = a2_sdram_q;
  assign AREA3_SDRAM      = a3_sdram_q;
  assign AREA5_CARD       = a5_card_q;
  assign AREA6_CARD       = a6_card_q;
  assign MEMTYPE_RESERVED = mt_rsvd_q;

  // checks on the configuration word and its decode
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);

  a_write_low_byte: assert property (
    CE && wr_fire && PSTRB[0] |=> cfg_q[7:0] == $past(PWDATA[7:0]))
    else $error("low byte write not stored");

  a_write_high_byte: assert property (
    CE && wr_fire && PSTRB[1] |=> cfg_q[15:12] == $past(PWDATA[15:12])
                                   && cfg_q[10:8] == $past(PWDATA[10:8]))
    else $error("high byte write not stored");

  a_hold_contents: assert property (
    !(CE && wr_fire) |=> $stable(cfg_q))
    else $error("word changed without a completed write");

  a_endian_readonly: assert property (
    captured_q |=> $stable(endian_q) && !cfg_q[BIT_ENDIAN])
    else $error("endian bit changed after capture");

  a_endian_capture: assert property (
    CE && capture_now |=> endian_q == $past(mode_s2_q) && captured_q)
    else $error("endian strap not captured");

  a_data_pullup: assert property (
    CE |=> DATA_PULLUP == $past(data_pullup_bit && DATA_BUS_IDLE))
    else $error("data pull-up wrong");

  a_standby_pins: assert property (
    CE && STANDBY |=> (MEM_STROBE_HIZ != MEM_STROBE_HIGH)
                      && MEM_STROBE_HIGH == $past(standby_strobe_float_ctl))
    else $error("standby strobe state wrong");

  a_ras_cas_float: assert property (
    CE && (STANDBY || BUS_RELEASED) |=> RAS_CAS_HIZ == !$past(row_col_strobe_float_ctl))
    else $error("row/column strobe state wrong");

  a_area0_burst: assert property (
    CE |=> AREA0_BURST_LEN == burst_len($past(a0_code)))
    else $error("area 0 burst length wrong");

  a_area56_burst: assert property (
    CE |=> AREA5_BURST_LEN == burst_len($past(a5_code))
           && AREA6_BURST_LEN == burst_len($past(a6_code)))
    else $error("area 5 or 6 burst length wrong");

  a_memtype_decode: assert property (
    CE |=> AREA2_SDRAM == ($past(mt_code) == MT_BOTH_SDR)
           && (!AREA2_SDRAM || AREA3_SDRAM) && !(MEMTYPE_RESERVED && AREA3_SDRAM))
    else $error("memory type decode wrong");

  a_card_select: assert property (
    CE |=> AREA5_CARD == $past(cfg_q[BIT_A5_CARD])
           && AREA6_CARD == $past(cfg_q[BIT_A6_CARD]))
    else $error("card space select wrong");

  a_bus_answer: assert property (
    CE && setup_ph && !MANUAL_RESET |=> PREADY && PSLVERR == !$past(addr_hit))
    else $error("bus answer not given in first access cycle");

  a_endian_wait: assert property (
    !capture_now && !captured_q |=> !captured_q)
    else $error("endian captured before the strap settled");

  a_read_data: assert property (
    CE && setup_ph && addr_hit |=> PRDATA[BIT_ENDIAN] == $past(endian_q)
      && PRDATA[APB_DATA_W-1:CFG_W] == '0 && PRDATA[10:0] == $past(cfg_q[10:0]))
    else $error("read data does not match the word");

  a_addr_pull_out: assert property (
    CE |=> ADDR_PULLUP == $past(pull.addr_pull))
    else $error("address pull-up output does not follow the window");

  a_strobe_idle: assert property (
    CE && !STANDBY |=> !MEM_STROBE_HIZ && !MEM_STROBE_HIGH)
    else $error("strobe standby state outside standby");

  a_ras_cas_idle: assert property (
    CE && !STANDBY && !BUS_RELEASED |=> !RAS_CAS_HIZ)
    else $error("row/column strobes floated while bus owned");

  a_manual_keep: assert property (
    MANUAL_RESET && !wr_fire |=> $stable(cfg_q))
    else $error("manual reset changed the word");

  a_standby_keep: assert property (
    STANDBY && !wr_fire |=> $stable(cfg_q))
    else $error("standby changed the word");

  a_low_lane_keep: assert property (
    CE && wr_fire && !PSTRB[0] |=> cfg_q[7:0] == $past(cfg_q[7:0]))
    else $error("low byte changed without its strobe");

  a_high_lane_keep: assert property (
    CE && wr_fire && !PSTRB[1] |=> cfg_q[15:8] == $past(cfg_q[15:8]))
    else $error("high byte changed without its strobe");

  a_ready_one_cycle: assert property (
    CE && access_done |=> !PREADY)
    else $error("ready held beyond one access cycle");

  a_reserved_flag: assert property (
    CE |=> MEMTYPE_RESERVED == ($past(mt_code) != MT_ORDINARY
      && $past(mt_code) != MT_A3_SDRAM && $past(mt_code) != MT_BOTH_SDR))
    else $error("reserved memory type flag wrong");

  a_area3_type: assert property (
    CE |=> AREA3_SDRAM == ($past(mt_code) == MT_A3_SDRAM || $past(mt_code) == MT_BOTH_SDR))
    else $error("area 3 memory type wrong");

endmodule : bacr_top
`default_nettype wire

// [sim/bacr_bus_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module bacr_bus_partner (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       give_bus,
  input  wire logic [3:0] ack_dly,
  input  wire logic       mem_busy,
  output logic            grant_ack_n,
  output logic            released,
  output logic            data_idle
);
  logic [3:0] wait_q;

  // grant acknowledge falls ack_dly cycles after the request, rises on return
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wait_q      <= 4'h0;
      grant_ack_n <= 1'b1;
      released    <= 1'b0;
    end else if (!give_bus) begin
      wait_q      <= 4'h0;
      grant_ack_n <= 1'b1;
      released    <= 1'b0;
    end else if (wait_q < ack_dly) begin
      wait_q <= wait_q + 4'h1;
    end else begin
      grant_ack_n <= 1'b0;
      released    <= 1'b1;
    end
  end

  // data pins unused whenever no memory cycle runs
  assign data_idle = !mem_busy;
endmodule : bacr_bus_partner
`default_nettype wire

// [sim/bacr_top_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module bacr_top_tb_top
  import bacr_pkg::*;
;
  logic                  clk, rstn, psel, penable, pwrite, err;
  logic                  give_bus, mem_busy, standby, man_rst, pready, pslverr;
  logic                  grant_n, released, data_idle, addr_pu, data_pu, hiz, high;
  logic                  rc_hiz, le, a2, a3, a5c, a6c, mt_res, strap, ce;
  logic [APB_ADDR_W-1:0] paddr;
  logic [APB_DATA_W-1:0] pwdata, prdata, rd;
  logic [3:0]            pstrb, ack_dly;
  logic [BLEN_W-1:0]     l0, l5, l6, len;
  logic [2:0]            mt;
  int                    error_cnt, samples_checked, cnt;

  bacr_top dut (.CLK_SYS(clk), .RSTN(rstn), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .BYTE_ORDER_MODE_PIN(strap),
    .GRANT_ACK_N_PIN(grant_n), .MANUAL_RESET(man_rst), .STANDBY(standby),
    .BUS_RELEASED(released), .DATA_BUS_IDLE(data_idle), .ADDR_PULLUP(addr_pu),
    .DATA_PULLUP(data_pu), .MEM_STROBE_HIZ(hiz), .MEM_STROBE_HIGH(high),
    .RAS_CAS_HIZ(rc_hiz), .LITTLE_ENDIAN(le), .AREA0_BURST_LEN(l0),
    .AREA5_BURST_LEN(l5), .AREA6_BURST_LEN(l6), .AREA2_SDRAM(a2), .AREA3_SDRAM(a3),
    .AREA5_CARD(a5c), .AREA6_CARD(a6c), .MEMTYPE_RESERVED(mt_res));

  bacr_bus_partner partner (.clk(clk), .rstn(rstn), .give_bus(give_bus), .ack_dly(ack_dly),
    .mem_busy(mem_busy), .grant_ack_n(grant_n), .released(released), .data_idle(data_idle));

  // free-running system clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // one bus transfer: setup, then access held until ready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clk);
    end
    if (n >= 50) error_cnt++;
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [15:0] d);
    apb(1'b1, CFG_OFFSET, {16'h0000, d}, 4'hF);
  endtask

  task automatic rdw;
    apb(1'b0, CFG_OFFSET, 32'h0000_0000, 4'h0);
  endtask

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    print_verdict();
  end

  // main sequence
  initial begin
    rstn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    pstrb = 4'h0; give_bus = 1'b0; ack_dly = 4'h0; mem_busy = 1'b0; standby = 1'b0;
    man_rst = 1'b0; error_cnt = 0; samples_checked = 0; rd = '0; err = 1'b0;
    strap = 1'b0; ce = 1'b1;
    tick(6);
    rstn <= 1'b1;
    tick(2);
    rdw();
    chk(rd, 32'h0000_0000);
    chk({l0, l5, l6, a2, a3, a5c, a6c, le, data_pu, addr_pu, rc_hiz, hiz}, 32'h0);
    // clock enable low freezes the pin controls
    ce      <= 1'b0;
    standby <= 1'b1;
    tick(3);
    chk(hiz, 1'b0);
    ce      <= 1'b1;
    tick(2);
    chk(hiz, 1'b1);
    standby <= 1'b0;
    wr(16'hFFEF);
    rdw();
    chk(rd, 32'h0000_F7EF);
    chk({a2, a3, mt_res}, 3'b110);
    chk(le, 1'b0);
    // low lane only: upper byte keeps its ones
    apb(1'b1, CFG_OFFSET, 32'h0000_0000, 4'h1);
    rdw();
    chk(rd, 32'h0000_F700);
    // unmapped word is refused and leaves the register alone
    apb(1'b1, 12'h004, 32'h0000_0000, 4'hF);
    chk(err, 1'b1);
    rdw();
    chk({err, rd[15:0]}, {1'b0, 16'hF700});
    // manual reset and a standby spell keep the contents
    man_rst <= 1'b1;
    standby <= 1'b1;
    tick(3);
    man_rst <= 1'b0;
    standby <= 1'b0;
    tick(2);
    rdw();
    chk(rd, 32'h0000_F700);
    // burst codes, memory types, card spaces
    for (int k = 0; k < 4; k++) begin
      mt = (k == 1) ? MT_A3_SDRAM : (k == 2) ? MT_BOTH_SDR : MT_ORDINARY;
      wr({5'h00, k[1:0], k[1:0], k[1:0], mt, k[0], k[1]});
      tick(2);
      len = (k == 0) ? 5'h00 : (5'h02 << k);
      chk({l0, l5, l6}, {len, len, len});
      chk({a2, a3, mt_res}, {k == 2, k == 1 || k == 2, 1'b0});
      chk({a5c, a6c}, {k[0], k[1]});
    end
    // strobe states in standby and bus release, data pull-up, slow grants with ack_dly 8 to 15
    for (int i = 0; i < 16; i++) begin
      wr({1'b0, i[0], i[0], i[1], 12'h000});
      standby  <= i[2];
      give_bus <= i[3];
      mem_busy <= i[1];
      ack_dly  <= 4'(i);
      tick(20);
      chk(hiz, i[2] & !i[0]);
      chk(high, i[2] & i[0]);
      chk(rc_hiz, (i[2] | i[3]) & !i[1]);
      chk(data_pu, i[0] & !i[1]);
      chk(addr_pu, 1'b0);
      give_bus <= 1'b0;
      standby  <= 1'b0;
      tick(2);
    end
    // address pull-up window length after grant acknowledge
    for (int j = 0; j < 2; j++) begin
      wr({j[0], 15'h0000});
      give_bus <= 1'b1;
      ack_dly  <= 4'(3 * j);
      cnt = 0;
      repeat (30) begin
        @(posedge clk);
        if (addr_pu === 1'b1) cnt++;
      end
      chk(32'(cnt), (j == 1) ? 32'h4 : 32'h0);
      give_bus <= 1'b0;
      tick(3);
    end
    // second power-on reset with the strap high: word cleared, bit 11 latched
    rstn  <= 1'b0;
    strap <= 1'b1;
    tick(6);
    rstn  <= 1'b1;
    tick(2);
    rdw();
    chk(rd, 32'h0000_0800);
    chk(le, 1'b1);
    wr(16'h0000);
    rdw();
    chk(rd, 32'h0000_0800);
    print_verdict();
  end
endmodule : bacr_top_tb_top
`default_nettype wire
